// *** pss_device.sv ***
// sequencer end: picks a table entry, walks chains, computes targets
// assumes the table is read combinationally by index on table_index and
// the profile generator reports move_done for each issued move
`timescale 1ns/10ps
module pss_device
  import pss_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  pss_if.device                          link,
  output logic [pss_pkg::ENTRY_W-1:0]    table_index,
  input  wire pss_pkg::pss_entry_t       table_entry,
  input  wire logic [pss_pkg::NUM_DIRECT*pss_pkg::ENTRY_W-1:0] direct_map,
  input  wire logic                      direct_map_load,
  input  wire logic                      seq_reset_event,
  input  wire logic                      move_done,
  output logic                           move_go,
  output logic signed [pss_pkg::POS_W-1:0] move_target,
  output logic                           move_press,
  output logic [pss_pkg::ENTRY_W:0]      current_entry
);
  import pss_pkg::*;

  typedef enum logic [2:0] {
    PSS_IDLE  = 3'b000,
    PSS_CHECK = 3'b001,
    PSS_ISSUE = 3'b010,
    PSS_MOVE  = 3'b011,
    PSS_DWELL = 3'b100
  } pss_state_t;

  typedef struct packed {
    pss_state_t                       st;
    logic [ENTRY_W-1:0]               entry;     // entry being run
    logic [ENTRY_W-1:0]               head;      // first entry of chain
    logic [ENTRY_W-1:0]               seq_start;
    logic [ENTRY_W-1:0]               last_run;
    logic                             have_last;
    logic [2:0]                       chain_len;
    logic [NUM_DIRECT*ENTRY_W-1:0]    dmap;
    logic                             start_q;
    logic                             net_q;
    logic                             step_q;
    logic [NUM_DIRECT-1:0]            direct_q;
    logic                             ready;
    logic                             data_error;
    logic signed [POS_W-1:0]          dest;
    logic                             go;
    logic                             press;
    logic [ENTRY_W:0]                 cur;
    logic [DWELL_W-1:0]               dwell_cnt;
    logic [16:0]                      tick_cnt;
  } pss_dev_state_t;

  pss_dev_state_t s;
  pss_dev_state_t next_s;

  function automatic logic [NUM_DIRECT*ENTRY_W-1:0] default_map();
    logic [NUM_DIRECT*ENTRY_W-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_DIRECT; i++) begin
      m[i*ENTRY_W +: ENTRY_W] = DIRECT_DEFAULT[i];
    end
    return m;
  endfunction

  localparam logic [NUM_DIRECT*ENTRY_W-1:0] DMAP_RESET = default_map();

  logic                 start_rise;
  logic                 net_rise;
  logic                 step_rise;
  logic [NUM_DIRECT-1:0] direct_rise;
  logic                 chain_fn;

  // rising edges of every start source
  assign start_rise  = link.start & ~s.start_q;
  assign net_rise    = link.net_start & ~s.net_q;
  assign step_rise   = link.sequence_step_trigger & ~s.step_q;
  assign direct_rise = link.direct_launch_inputs & ~s.direct_q;
  assign chain_fn    = (table_entry.func == PSS_FN_CHAIN) ||
                       (table_entry.func == PSS_FN_DWELL);

  // table is addressed by the entry in flight
  assign table_index = s.entry;

  always_comb begin
    next_s          = s;
    next_s.start_q  = link.start;
    next_s.net_q    = link.net_start;
    next_s.step_q   = link.sequence_step_trigger;
    next_s.direct_q = link.direct_launch_inputs;
    next_s.go       = 1'b0;
    if (direct_map_load) begin
      next_s.dmap = direct_map;
    end
    unique case (s.st)
      PSS_IDLE: begin
        // edges seen while busy are simply dropped
        if (s.ready) begin
          if (start_rise || net_rise) begin
            // network path samples select in the same cycle as start
            next_s.entry = net_rise ? link.network_entry_number_select
                                    : link.entry_number_select_inputs;
            next_s.seq_start = next_s.entry;
            next_s.st = PSS_CHECK;
          end else if (|direct_rise) begin
            for (int i = NUM_DIRECT - 1; i >= 0; i--) begin
              if (direct_rise[i]) begin
                next_s.entry = s.dmap[i*ENTRY_W +: ENTRY_W];
              end
            end
            next_s.st = PSS_CHECK;
          end else if (step_rise) begin
            // first step with no history runs the sequence start
            next_s.entry = s.have_last ? pss_next(s.last_run)
                                       : s.seq_start;
            next_s.st = PSS_CHECK;
          end
          if (next_s.st == PSS_CHECK) begin
            next_s.ready      = 1'b0;
            next_s.data_error = 1'b0;
            next_s.head       = next_s.entry;
            next_s.chain_len  = 3'h1;
          end
        end
      end
      PSS_CHECK: begin
        // a step onto a disabled entry wraps to the sequence start
        if (step_rise == 1'b0 && s.have_last && !table_entry.seq_enable &&
            s.entry == pss_next(s.last_run) && s.entry != s.seq_start &&
            s.head == s.entry && s.chain_len == 3'h1 && s.step_q) begin
          next_s.entry = s.seq_start;
          next_s.head  = s.seq_start;
        end else begin
          next_s.st = PSS_ISSUE;
        end
      end
      PSS_ISSUE: begin
        if (s.chain_len > CHAIN_LIMIT) begin
          next_s.data_error = 1'b1;
          next_s.ready      = 1'b1;
          next_s.st         = PSS_IDLE;
        end else begin
          if (table_entry.mode == PSS_MODE_ABS) begin
            next_s.dest = table_entry.position;
          end else begin
            next_s.dest = s.dest + table_entry.position;
          end
          next_s.press = (table_entry.func == PSS_FN_PRESS);
          next_s.go    = 1'b1;
          next_s.cur   = {1'b0, s.entry};
          next_s.st    = PSS_MOVE;
        end
      end
      PSS_MOVE: begin
        if (move_done) begin
          next_s.press = 1'b0;
          // entry 63 never links onward
          if (chain_fn && s.entry != LAST_ENTRY) begin
            next_s.entry     = pss_next(s.entry);
            next_s.chain_len = s.chain_len + 3'h1;
            next_s.tick_cnt  = '0;
            next_s.dwell_cnt = table_entry.dwell;
            next_s.st = (table_entry.func == PSS_FN_DWELL) ? PSS_DWELL
                                                           : PSS_ISSUE;
          end else begin
            next_s.last_run  = s.entry;
            next_s.have_last = 1'b1;
            next_s.ready     = 1'b1;
            next_s.st        = PSS_IDLE;
          end
        end
      end
      PSS_DWELL: begin
        // counts whole milliseconds; direction may reverse after it
        if (s.dwell_cnt == '0) begin
          next_s.st = PSS_ISSUE;
        end else if (s.tick_cnt == DWELL_TICK_M1) begin
          next_s.tick_cnt  = '0;
          next_s.dwell_cnt = s.dwell_cnt - 16'h0001;
        end else begin
          next_s.tick_cnt = s.tick_cnt + 17'h0_0001;
        end
      end
      default: next_s.st = PSS_IDLE;
    endcase
    // reset events abort and restore the sequence origin
    if (seq_reset_event) begin
      next_s.seq_start = ENTRY_ZERO;
      next_s.have_last = 1'b0;
      next_s.cur       = CUR_NONE;
      next_s.st        = PSS_IDLE;
      next_s.ready     = 1'b1;
      next_s.press     = 1'b0;
      next_s.go        = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s            <= '0;
      s.st         <= PSS_IDLE;
      s.dmap       <= DMAP_RESET;
      s.ready      <= 1'b1;
      s.cur        <= CUR_NONE;
      s.seq_start  <= ENTRY_ZERO;
    end else begin
      s <= next_s;
    end
  end

  assign link.ready      = s.ready;
  assign link.data_error = s.data_error;
  assign move_go         = s.go;
  assign move_target     = s.dest;
  assign move_press      = s.press;
  assign current_entry   = s.cur;
endmodule

// *** pss_pkg.sv ***
// package of constants and types for the positioning start sequencer
// assumes one 100 MHz clock shared by both ends and the carrier interface
// Notes on behaviour
// - absolute mode: target measured from home
// - incremental mode: add to previous target
// - function codes: single, chain, dwell, press
// - single move runs one entry, stops
// - dwell between chained entries, reversal allowed
// - pressing move holds force on stall
// - chain over four entries raises data error
// - six select bits pick entry 0..63
// - host checks ready before any start
// - ready drops on accept; host waits
// - ready returns when move finishes
// - network select and start may coincide
// - direct input launches its assigned entry
// - direct entries configurable, default 0..5
// - host holds direct input until ready low
// - step trigger launches next entry
// - disabled next entry wraps to start
// - sequential flag one bit, default off
// - number-select start sets new sequence start
// - no start point: step launches entry 0
// - reset events: start 0, current -1
// - host releases step after ready low
// - chained stepped entries need sequential flag
package pss_pkg;
  localparam int ENTRY_W     = 6;
  localparam int NUM_ENTRIES = 64;
  localparam int NUM_DIRECT  = 6;
  localparam int POS_W       = 24;
  localparam int DWELL_W     = 16;
  localparam int MAX_CHAIN   = 4;
  localparam logic [ENTRY_W-1:0] LAST_ENTRY = 6'h3f;
  localparam logic [ENTRY_W-1:0] ENTRY_ZERO = 6'h00;
  localparam logic [ENTRY_W:0]   CUR_NONE   = 7'h7f; // current entry of -1
  // dwell unit 1 ms at 100 MHz
  localparam int CLK_MHZ    = 100;
  localparam int DWELL_UNIT_US = 1000;
  localparam int DWELL_TICK = CLK_MHZ * DWELL_UNIT_US;
  localparam logic [16:0] DWELL_TICK_M1 = 17'(DWELL_TICK - 1);
  localparam logic [2:0]  CHAIN_LIMIT = 3'(MAX_CHAIN);

  typedef enum logic [1:0] {
    PSS_FN_SINGLE = 2'b00,
    PSS_FN_CHAIN  = 2'b01,
    PSS_FN_DWELL  = 2'b10,
    PSS_FN_PRESS  = 2'b11
  } pss_fn_t;

  typedef enum logic [1:0] {
    PSS_MODE_INC = 2'b00,
    PSS_MODE_ABS = 2'b01
  } pss_mode_t;

  // one table entry as handed to the sequencer
  typedef struct packed {
    logic signed [POS_W-1:0] position;
    pss_mode_t               mode;
    pss_fn_t                 func;
    logic [DWELL_W-1:0]      dwell;
    logic                    seq_enable;
  } pss_entry_t;

  localparam logic [5:0] DIRECT_DEFAULT [NUM_DIRECT] =
    '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05};

  // next entry with wrap past 63 onto 0
  function automatic logic [ENTRY_W-1:0] pss_next(
      input logic [ENTRY_W-1:0] e);
    return e + 6'h01;
  endfunction
endpackage

// *** pss_if.sv ***
// carrier between the host end and the sequencer end
// assumes both ends share sys_clk; all signals are plain levels
`timescale 1ns/10ps
interface pss_if;
  import pss_pkg::*;
  logic [ENTRY_W-1:0]    entry_number_select_inputs;
  logic [ENTRY_W-1:0]    network_entry_number_select;
  logic                  start;
  logic                  net_start;
  logic [NUM_DIRECT-1:0] direct_launch_inputs;
  logic                  sequence_step_trigger;
  logic                  ready;
  logic                  data_error;
  modport device (
    input  entry_number_select_inputs,
    input  network_entry_number_select,
    input  start,
    input  net_start,
    input  direct_launch_inputs,
    input  sequence_step_trigger,
    output ready,
    output data_error
  );
  modport host (
    output entry_number_select_inputs,
    output network_entry_number_select,
    output start,
    output net_start,
    output direct_launch_inputs,
    output sequence_step_trigger,
    input  ready,
    input  data_error
  );
endinterface

// *** pss_host.sv ***
// host end: turns one-cycle user requests into held start levels
// assumes the sequencer end on the far side of the interface
`timescale 1ns/10ps
module pss_host
  import pss_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  pss_if.host                              link,
  input  wire logic                        req_select,
  input  wire logic                        req_network,
  input  wire logic [pss_pkg::ENTRY_W-1:0] req_entry,
  input  wire logic                        req_direct,
  input  wire logic [2:0]                  req_direct_idx,
  input  wire logic                        req_step,
  output logic                             req_taken,
  output logic                             busy,
  output logic                             dev_error
);
  import pss_pkg::*;

  typedef enum logic [1:0] {
    PSH_IDLE  = 2'b00,
    PSH_SETUP = 2'b01,
    PSH_HOLD  = 2'b10,
    PSH_WAIT  = 2'b11
  } psh_state_t;

  typedef struct packed {
    psh_state_t             st;
    logic [ENTRY_W-1:0]     sel;
    logic [ENTRY_W-1:0]     net_sel;
    logic                   start;
    logic                   net_start;
    logic [NUM_DIRECT-1:0]  direct;
    logic                   step;
    logic                   taken;
    logic                   err;
    logic                   busy;
  } psh_state_all_t;

  psh_state_all_t h;
  psh_state_all_t next_h;

  always_comb begin
    next_h       = h;
    next_h.taken = 1'b0;
    next_h.err   = link.data_error;
    unique case (h.st)
      PSH_IDLE: begin
        // requests are taken only while the device reports ready
        if (link.ready) begin
          next_h.taken = req_select | req_network | req_direct | req_step;
          if (req_network) begin
            next_h.net_sel   = req_entry;
            next_h.net_start = 1'b1;
            next_h.st        = PSH_HOLD;
          end else if (req_select) begin
            next_h.sel = req_entry;
            next_h.st  = PSH_SETUP;
          end else if (req_direct) begin
            next_h.direct = NUM_DIRECT'(1) << req_direct_idx;
            next_h.st     = PSH_HOLD;
          end else if (req_step) begin
            next_h.step = 1'b1;
            next_h.st   = PSH_HOLD;
          end
        end
      end
      PSH_SETUP: begin
        // discrete select settles one cycle ahead of start
        next_h.start = 1'b1;
        next_h.st    = PSH_HOLD;
      end
      PSH_HOLD: begin
        if (!link.ready) begin
          next_h.start     = 1'b0;
          next_h.net_start = 1'b0;
          next_h.direct    = '0;
          next_h.step      = 1'b0;
          next_h.st        = PSH_WAIT;
        end
      end
      PSH_WAIT: begin
        if (link.ready) begin
          next_h.st = PSH_IDLE;
        end
      end
    endcase
    // busy is registered so the output comes straight from a flop
    next_h.busy = (next_h.st != PSH_IDLE);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      h    <= '0;
      h.st <= PSH_IDLE;
    end else begin
      h <= next_h;
    end
  end

  assign link.entry_number_select_inputs  = h.sel;
  assign link.network_entry_number_select = h.net_sel;
  assign link.start                       = h.start;
  assign link.net_start                   = h.net_start;
  assign link.direct_launch_inputs        = h.direct;
  assign link.sequence_step_trigger       = h.step;
  assign req_taken                        = h.taken;
  assign busy                             = h.busy;
  assign dev_error                        = h.err;
endmodule

// *** pss_chk.sv ***
// checker on the carrier signals between the host and sequencer ends
// assumes one sys_clk domain and reset_n shared by both ends
`timescale 1ns/10ps
module pss_chk
  import pss_pkg::*;
(
  input wire logic                          sys_clk,
  input wire logic                          reset_n,
  input wire logic [pss_pkg::ENTRY_W-1:0]    entry_number_select_inputs,
  input wire logic                          start,
  input wire logic                          net_start,
  input wire logic [pss_pkg::NUM_DIRECT-1:0] direct_launch_inputs,
  input wire logic                          sequence_step_trigger,
  input wire logic                          ready,
  input wire logic                          data_error
);
  import pss_pkg::*;
  logic any_start;

  // any launch source raised by the host, seen as one request line
  assign any_start = start | net_start | (|direct_launch_inputs)
                     | sequence_step_trigger;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sel_accept_a: assert property ($rose(start) && ready |=> !ready)
    else $error("select start did not drop ready");
  net_accept_a: assert property ($rose(net_start) && ready |=> !ready)
    else $error("network start did not drop ready");
  direct_accept_a: assert property (
    $rose(|direct_launch_inputs) && ready |=> !ready)
    else $error("direct launch did not drop ready");
  step_accept_a: assert property (
    $rose(sequence_step_trigger) && ready |=> !ready)
    else $error("step trigger did not drop ready");
  host_ready_a: assert property ($rose(any_start) |-> ready)
    else $error("host raised a start while not ready");
  start_hold_a: assert property (
    any_start && ready |=> any_start)
    else $error("host released a start before ready fell");
  select_setup_a: assert property (
    $rose(start) |-> $stable(entry_number_select_inputs))
    else $error("select inputs moved with the start edge");
  error_ready_a: assert property ($rose(data_error) |-> ##[0:1] ready)
    else $error("chain error left ready low");
endmodule

// *** pss_tb.sv ***
// self-checking bench: host end joined to sequencer end over pss_if
// assumes 100 MHz sys_clk; table and profile generator are modelled here
`timescale 1ns/10ps
module positioning_start_sequencer_tb;
  import pss_pkg::*;
  logic               sys_clk         = 1'b0;
  logic               reset_n         = 1'b0;
  logic               req_select      = 1'b0;
  logic               req_network     = 1'b0;
  logic               req_direct      = 1'b0;
  logic               req_step        = 1'b0;
  logic [5:0]         req_entry       = 6'h00;
  logic [2:0]         req_direct_idx  = 3'h0;
  logic [35:0]        direct_map      = 36'h0_0000_0000;
  logic               direct_map_load = 1'b0;
  logic               seq_reset_event = 1'b0;
  logic               move_done       = 1'b0;
  logic signed [23:0] dest            = 24'h00_0000;
  logic               req_taken;
  logic               busy;
  logic               dev_error;
  logic [5:0]         table_index;
  logic               move_go;
  logic signed [23:0] move_target;
  logic               move_press;
  logic [6:0]         current_entry;
  pss_entry_t         tbl [NUM_ENTRIES];
  pss_entry_t         table_entry;
  int                 bad_count       = 0;
  int                 n_tests         = 0;
  int                 cycles          = 0;

  pss_if pss_if_i ();
  pss_host pss_host_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .link(pss_if_i), .req_select(req_select), .req_network(req_network),
    .req_entry(req_entry), .req_direct(req_direct),
    .req_direct_idx(req_direct_idx), .req_step(req_step),
    .req_taken(req_taken), .busy(busy), .dev_error(dev_error));
  pss_device pss_device_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .link(pss_if_i), .table_index(table_index), .table_entry(table_entry),
    .direct_map(direct_map), .direct_map_load(direct_map_load),
    .seq_reset_event(seq_reset_event), .move_done(move_done),
    .move_go(move_go), .move_target(move_target), .move_press(move_press),
    .current_entry(current_entry));
  pss_chk pss_chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .entry_number_select_inputs(pss_if_i.entry_number_select_inputs),
    .start(pss_if_i.start), .net_start(pss_if_i.net_start),
    .direct_launch_inputs(pss_if_i.direct_launch_inputs),
    .sequence_step_trigger(pss_if_i.sequence_step_trigger),
    .ready(pss_if_i.ready), .data_error(pss_if_i.data_error));

  // table read combinationally, as the sequencer expects
  assign table_entry = tbl[table_index];

  always #5 sys_clk = ~sys_clk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp_v(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_b(input logic got, input logic exp);
    cmp_v({23'h00_0000, got}, {23'h00_0000, exp});
  endtask

  task automatic st(input int i, input logic [23:0] p, input pss_mode_t m,
                    input pss_fn_t f, input logic s);
    tbl[i] = '{p, m, f, 16'h0000, s};
  endtask

  // one launch: pulse a request, answer each move, then wait for idle;
  // the expected target is tracked here, so inc vs abs mixups show up
  task automatic op(input int kind, input logic [5:0] arg,
                    input logic [5:0] first, input int moves,
                    input logic chk_cur);
    logic [5:0] e;
    int         w;
    e = first;
    @(negedge sys_clk);
    case (kind)
      0: req_select = 1'b1;
      1: req_network = 1'b1;
      2: req_direct = 1'b1;
      default: req_step = 1'b1;
    endcase
    req_entry = arg;
    req_direct_idx = arg[2:0];
    @(negedge sys_clk);
    cmp_b(req_taken, 1'b1);
    {req_select, req_network, req_direct, req_step} = 4'h0;
    repeat (moves) begin
      w = 0;
      while (move_go !== 1'b1 && w < 200) begin
        @(negedge sys_clk);
        w++;
      end
      if (tbl[e].mode == PSS_MODE_ABS) dest = tbl[e].position;
      else dest = dest + tbl[e].position;
      cmp_b(move_go, 1'b1);
      cmp_v(24'(table_index), 24'(e));
      cmp_v(move_target, dest);
      cmp_b(move_press, tbl[e].func == PSS_FN_PRESS);
      move_done = 1'b1;
      @(negedge sys_clk);
      move_done = 1'b0;
      e = e + 6'h01;
    end
    w = 0;
    while (pss_if_i.ready !== 1'b1 && w < 200) begin
      @(negedge sys_clk);
      w++;
    end
    @(negedge sys_clk);
    cmp_b(pss_if_i.ready, 1'b1);
    cmp_b(busy, 1'b0);
    if (chk_cur) cmp_v(24'(current_entry), 24'({1'b0, e - 6'h01}));
  endtask

  task automatic t_reset();
    cmp_b(pss_if_i.ready, 1'b1);
    cmp_b(pss_if_i.data_error, 1'b0);
    cmp_v(24'(current_entry), 24'(CUR_NONE));
    $display("reset test done");
  endtask

  task automatic t_step();
    op(3, 6'h00, 6'h00, 1, 1'b1);
    op(3, 6'h00, 6'h01, 1, 1'b1);
    op(3, 6'h00, 6'h02, 1, 1'b1);
    op(3, 6'h00, 6'h00, 1, 1'b1);
    $display("step test done");
  endtask

  task automatic t_select();
    op(0, 6'h14, 6'h14, 1, 1'b1);
    op(3, 6'h00, 6'h15, 1, 1'b1);
    op(3, 6'h00, 6'h14, 1, 1'b1);
    $display("select test done");
  endtask

  task automatic t_seqrst();
    @(negedge sys_clk);
    seq_reset_event = 1'b1;
    @(negedge sys_clk);
    seq_reset_event = 1'b0;
    @(negedge sys_clk);
    cmp_v(24'(current_entry), 24'(CUR_NONE));
    op(3, 6'h00, 6'h00, 1, 1'b1);
    $display("sequence reset test done");
  endtask

  task automatic t_chain();
    op(0, 6'h0a, 6'h0a, 3, 1'b1);
    op(1, 6'h3f, 6'h3f, 1, 1'b1);
    $display("chain test done");
  endtask

  task automatic t_direct();
    op(2, 6'h02, 6'h02, 1, 1'b1);
    @(negedge sys_clk);
    direct_map = {6'h28, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};
    direct_map_load = 1'b1;
    @(negedge sys_clk);
    direct_map_load = 1'b0;
    op(2, 6'h05, 6'h28, 1, 1'b1);
    $display("direct test done");
  endtask

  // five linked entries: four run, the fifth is refused with an error
  task automatic t_limit();
    op(0, 6'h1e, 6'h1e, 4, 1'b0);
    cmp_b(pss_if_i.data_error, 1'b1);
    cmp_b(dev_error, 1'b1);
    $display("chain limit test done");
  endtask

  initial begin
    foreach (tbl[i]) tbl[i] = '{24'h00_0000, PSS_MODE_INC, PSS_FN_SINGLE,
                                16'h0000, 1'b0};
    st(0, 24'h00_0064, PSS_MODE_INC, PSS_FN_SINGLE, 1'b1);
    st(1, 24'h00_00c8, PSS_MODE_INC, PSS_FN_SINGLE, 1'b1);
    st(2, 24'h00_0032, PSS_MODE_ABS, PSS_FN_SINGLE, 1'b1);
    // chains are launched by select or network start only, so their step flag stays off
    st(10, 24'h00_03e8, PSS_MODE_INC, PSS_FN_CHAIN, 1'b0);
    st(11, 24'hff_fe70, PSS_MODE_INC, PSS_FN_DWELL, 1'b0);
    st(12, 24'h00_0005, PSS_MODE_ABS, PSS_FN_PRESS, 1'b0);
    st(20, 24'h00_0007, PSS_MODE_INC, PSS_FN_SINGLE, 1'b1);
    st(21, 24'hff_fff7, PSS_MODE_INC, PSS_FN_SINGLE, 1'b1);
    for (int i = 30; i < 34; i++) st(i, 24'h00_0010, PSS_MODE_INC,
                                     PSS_FN_CHAIN, 1'b0);
    st(40, 24'h00_0001, PSS_MODE_INC, PSS_FN_SINGLE, 1'b0);
    st(63, 24'hff_fc18, PSS_MODE_ABS, PSS_FN_CHAIN, 1'b0);
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_step();
    t_select();
    t_seqrst();
    t_chain();
    t_direct();
    t_limit();
    finish_test();
  end
endmodule
